// file: src/sxch_pkg.sv
// sxch_pkg: constants and types shared by the extended command handler
package sxch_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam longint CLK_HZ = 200000000;
	localparam int TICK_TIME_MS = 1;
	localparam int TICK_CYC = int'(CLK_HZ / 1000) * TICK_TIME_MS;
	localparam int WAKE_TIME_S = 60;
	localparam int WAKE_TICKS = WAKE_TIME_S * 1000 / TICK_TIME_MS;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_PARAM = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RESP = 8'h10;
	localparam logic [7:0] OFS_IIR = 8'h14;
	localparam logic [7:0] OFS_CFG = 8'h18;
	localparam logic [7:0] OFS_BKG = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CMD_SET_BIT = 4;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RESP_BIT = 1;
	localparam int ST_SLEEP_BIT = 2;
	localparam int ST_BKG_BIT = 3;
	localparam int ST_HOLD_BIT = 4;
	localparam int CFG_PEAK_BIT = 0;
	localparam int CFG_SUPP_LSB = 1;
	localparam int CFG_FCAL_BIT = 3;
	localparam int CFG_WAVE_LSB = 16;

	// ----------------------------------------------------------------
	// values after reset and factory defaults
	// ----------------------------------------------------------------
	localparam logic [31:0] IIR_DEFAULT = 32'h0000_8000;
	localparam logic PEAK_DEFAULT = 1'b0;
	localparam logic [11:0] WAVE_DEFAULT = 12'h4B0;
	localparam logic [11:0] WAVE_MAX = 12'hE10;
	localparam logic [1:0] SUPP_DEFAULT = 2'h0;
	localparam logic FCAL_DEFAULT = 1'b0;
	localparam logic [7:0] ADDR_DEFAULT = 8'h30;
	localparam logic [31:0] ACK_ONE = 32'h0000_0001;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_IIR = 4'h0,
		OP_PEAK = 4'h1,
		OP_WAVE = 4'h2,
		OP_SUPP = 4'h3,
		OP_BKG = 4'h4,
		OP_WAKE = 4'h5,
		OP_RECAL = 4'h6,
		OP_DEFAULTS = 4'h7,
		OP_FCAL = 4'h8,
		OP_MEASURE = 4'h9,
		OP_STD = 4'hA
	} sxch_op_t;

	// power states, gray along sleep, active, wake window, held
	typedef enum logic [1:0] {
		PW_SLEEP = 2'h0,
		PW_MEAS = 2'h1,
		PW_WAKE = 2'h3,
		PW_HELD = 2'h2
	} sxch_pwr_t;

endpackage

// file: src/sxch_tick.sv
// sxch_tick: free running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
module sxch_tick #(
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// enable pulse
	output logic tick
);
	logic [31:0] cnt_r;

	// count DIV cycles, pulse on the last one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt_r == 32'(DIV - 1)) begin
			cnt_r <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule // sxch_tick

// file: src/sxch_handler.sv
// sxch_handler: extended configuration command handler with Avalon-MM registers
//
// Summary of operation
// RL1: get IIR constant answers address plus constant
// RL2: host keeps IIR constant within zero to one
// RL3: peak select 0 reports strongest echo distance
// RL4: peak select 1 reports furthest echo distance
// RL5: wave length limited to 3600, echoed back
// RL6: suppression code masks wave and angle sentences
// RL7: nonzero background save stores curve to distance
// RL8: with background, only stronger echoes count; beyond the stored distance every echo counts
// RL9: background save with zero clears reference
// RL10: in SDI-12 mode sleep until measure
// RL11: serial ports closed while asleep
// RL12: wake command keeps device active 60 seconds
// RL13: serial connection in window holds device awake
// RL14: recalibrate clears, recalibrates, answers one
// RL15: factory reset restores defaults, answers one
// RL16: host power-cycles after factory reset
// RL17: forced calibration is 0 or 1, echoed
// RL18: other standard commands answered too
// RL19: set commands store then echo stored value
`timescale 1ns/1ps
module sxch_handler #(
	parameter int TICK_CYC = sxch_pkg::TICK_CYC,
	parameter int WAKE_TICKS = sxch_pkg::WAKE_TICKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// echo processing
	input wire logic [31:0] max_peak_dist,
	input wire logic [31:0] last_peak_dist,
	input wire logic [31:0] echo_dist,
	input wire logic [15:0] echo_amp,
	input wire logic [15:0] echo_ref_amp,
	output logic [31:0] level_dist,
	output logic echo_accept,
	output logic bkg_capture,
	output logic [31:0] bkg_range,
	// calibration engine
	input wire logic cal_done,
	output logic cal_clear,
	output logic cal_start,
	output logic cal_forced,
	// sentence output and filter
	output logic wave_sentence_en,
	output logic angle_sentence_en,
	output logic [31:0] iir_constant,
	output logic [11:0] wave_window,
	// power and serial ports
	input wire logic sdi12_mode,
	input wire logic serial_connected,
	input wire logic meas_done,
	output logic meas_start,
	output logic serial_enable,
	output logic asleep
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [3:0] last_op;
		logic [31:0] param;
		logic [7:0] addr;
		logic busy;
		logic resp_valid;
		logic [31:0] resp;
		logic [31:0] iir;
		logic peak_last;
		logic [11:0] wave;
		logic [1:0] supp;
		logic fcal;
		logic bkg_valid;
		logic [31:0] bkg_dist;
		logic bkg_cap;
		logic cal_clr;
		logic cal_go;
		logic meas_go;
		sxch_pkg::sxch_pwr_t pwr;
		logic [31:0] wake_cnt;
		logic [31:0] level;
		logic accept;
	} sxch_state_t;

	sxch_state_t s_r;
	sxch_state_t s_nxt;
	logic tick;
	logic wr_now;
	logic cmd_go;
	logic [31:0] status_word;
	logic [31:0] cfg_word;

	// ----------------------------------------------------------------
	// millisecond enable
	// ----------------------------------------------------------------
	sxch_tick #(
		.DIV(TICK_CYC)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick)
	);

	// bus: one wait cycle, write lands on the edge waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
	assign wr_now = avs_write & s_r.ack;
	// a command arriving while busy is dropped
	assign cmd_go = wr_now & (avs_address == sxch_pkg::OFS_CMD) & ~s_r.busy;

	// status and configuration read views
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[sxch_pkg::ST_BUSY_BIT] = s_r.busy;
		status_word[sxch_pkg::ST_RESP_BIT] = s_r.resp_valid;
		status_word[sxch_pkg::ST_SLEEP_BIT] = asleep;
		status_word[sxch_pkg::ST_BKG_BIT] = s_r.bkg_valid;
		status_word[sxch_pkg::ST_HOLD_BIT] = (s_r.pwr == sxch_pkg::PW_HELD);
		cfg_word = 32'h0000_0000;
		cfg_word[sxch_pkg::CFG_PEAK_BIT] = s_r.peak_last;
		cfg_word[sxch_pkg::CFG_SUPP_LSB +: 2] = s_r.supp;
		cfg_word[sxch_pkg::CFG_FCAL_BIT] = s_r.fcal;
		cfg_word[sxch_pkg::CFG_WAVE_LSB +: 12] = s_r.wave;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.bkg_cap = 1'b0;
		s_nxt.cal_clr = 1'b0;
		s_nxt.cal_go = 1'b0;
		s_nxt.meas_go = 1'b0;

		// bus handshake and read data capture
		s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
		if (avs_read & ~s_r.ack) begin
			case (avs_address)
				sxch_pkg::OFS_CMD: s_nxt.rdata = {28'h0000000, s_r.last_op};
				sxch_pkg::OFS_PARAM: s_nxt.rdata = s_r.param;
				sxch_pkg::OFS_ADDR: s_nxt.rdata = {24'h000000, s_r.addr};
				sxch_pkg::OFS_STATUS: s_nxt.rdata = status_word;
				sxch_pkg::OFS_RESP: s_nxt.rdata = s_r.resp;
				sxch_pkg::OFS_IIR: s_nxt.rdata = s_r.iir;
				sxch_pkg::OFS_CFG: s_nxt.rdata = cfg_word;
				sxch_pkg::OFS_BKG: s_nxt.rdata = s_r.bkg_dist;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// plain register writes
		if (wr_now && avs_address == sxch_pkg::OFS_PARAM) begin
			s_nxt.param = avs_writedata;
		end
		if (wr_now && avs_address == sxch_pkg::OFS_ADDR) begin
			s_nxt.addr = avs_writedata[7:0];
		end
		// writing one to the response bit clears it
		if (wr_now && avs_address == sxch_pkg::OFS_STATUS &&
			avs_writedata[sxch_pkg::ST_RESP_BIT]) begin
			s_nxt.resp_valid = 1'b0;
		end

		// command execution; the answer is prefixed with addr by software
		if (cmd_go) begin
			s_nxt.last_op = avs_writedata[3:0];
			s_nxt.resp_valid = 1'b1;
			case (avs_writedata[3:0])
				sxch_pkg::OP_IIR: begin
					// out-of-range constants are kept as given
					if (avs_writedata[sxch_pkg::CMD_SET_BIT]) begin
						s_nxt.iir = s_r.param; // see RL2
					end
					s_nxt.resp = avs_writedata[sxch_pkg::CMD_SET_BIT] ?
						s_r.param : s_r.iir; // see RL1
				end
				sxch_pkg::OP_PEAK: begin
					if (avs_writedata[sxch_pkg::CMD_SET_BIT]) begin
						s_nxt.peak_last = s_r.param[0];
					end
					s_nxt.resp = {31'h0, avs_writedata[sxch_pkg::CMD_SET_BIT] ?
						s_r.param[0] : s_r.peak_last}; // see RL19
				end
				sxch_pkg::OP_WAVE: begin
					if (avs_writedata[sxch_pkg::CMD_SET_BIT]) begin
						// clamp to the top of the allowed range
						s_nxt.wave = (s_r.param > {20'h0, sxch_pkg::WAVE_MAX}) ?
							sxch_pkg::WAVE_MAX : s_r.param[11:0]; // see RL5
					end
					s_nxt.resp = {20'h0, s_nxt.wave}; // see RL5
				end
				sxch_pkg::OP_SUPP: begin
					if (avs_writedata[sxch_pkg::CMD_SET_BIT]) begin
						s_nxt.supp = s_r.param[1:0];
					end
					s_nxt.resp = {30'h0, s_nxt.supp}; // see RL19
				end
				sxch_pkg::OP_BKG: begin
					s_nxt.bkg_dist = s_r.param;
					if (s_r.param == 32'h0000_0000) begin
						s_nxt.bkg_valid = 1'b0; // see RL9
					end else begin
						s_nxt.bkg_valid = 1'b1; // see RL7
						s_nxt.bkg_cap = 1'b1; // see RL7
					end
					s_nxt.resp = s_r.param;
				end
				sxch_pkg::OP_WAKE: begin
					s_nxt.resp = 32'h0000_0000;
				end
				sxch_pkg::OP_RECAL: begin
					// answer held back until the engine finishes
					s_nxt.busy = 1'b1;
					s_nxt.resp_valid = 1'b0;
					s_nxt.cal_clr = 1'b1; // see RL14
					s_nxt.cal_go = 1'b1; // see RL14
				end
				sxch_pkg::OP_DEFAULTS: begin
					s_nxt.iir = sxch_pkg::IIR_DEFAULT; // see RL15
					s_nxt.peak_last = sxch_pkg::PEAK_DEFAULT;
					s_nxt.wave = sxch_pkg::WAVE_DEFAULT;
					s_nxt.supp = sxch_pkg::SUPP_DEFAULT;
					s_nxt.fcal = sxch_pkg::FCAL_DEFAULT;
					s_nxt.bkg_valid = 1'b0;
					s_nxt.bkg_dist = 32'h0000_0000;
					s_nxt.resp = sxch_pkg::ACK_ONE; // see RL15
				end
				sxch_pkg::OP_FCAL: begin
					// any nonzero value means on
					if (avs_writedata[sxch_pkg::CMD_SET_BIT]) begin
						s_nxt.fcal = (s_r.param != 32'h0000_0000); // see RL17
					end
					s_nxt.resp = {31'h0, s_nxt.fcal}; // see RL17
				end
				sxch_pkg::OP_MEASURE: begin
					s_nxt.meas_go = 1'b1;
					s_nxt.resp = 32'h0000_0000; // see RL18
				end
				default: begin
					// other standard commands get an empty answer
					s_nxt.resp = 32'h0000_0000; // see RL18
				end
			endcase
		end

		// calibration finished: answer one; set wins over software clear
		if (s_r.busy && cal_done) begin
			s_nxt.busy = 1'b0;
			s_nxt.resp_valid = 1'b1;
			s_nxt.resp = sxch_pkg::ACK_ONE; // see RL14
		end

		// ------------------------------------------------------------
		// power state
		// ------------------------------------------------------------
		case (s_r.pwr)
			sxch_pkg::PW_SLEEP: begin
				if (s_nxt.meas_go) begin
					s_nxt.pwr = sxch_pkg::PW_MEAS; // see RL10
				end else if (cmd_go && avs_writedata[3:0] == sxch_pkg::OP_WAKE) begin
					s_nxt.pwr = sxch_pkg::PW_WAKE; // see RL12
					s_nxt.wake_cnt = 32'h0000_0000;
				end
			end
			sxch_pkg::PW_MEAS: begin
				if (meas_done) begin
					s_nxt.pwr = sxch_pkg::PW_SLEEP; // see RL10
				end
			end
			sxch_pkg::PW_WAKE: begin
				if (serial_connected) begin
					s_nxt.pwr = sxch_pkg::PW_HELD; // see RL13
				end else if (cmd_go && avs_writedata[3:0] == sxch_pkg::OP_WAKE) begin
					s_nxt.wake_cnt = 32'h0000_0000;
				end else if (tick) begin
					if (s_r.wake_cnt == 32'(WAKE_TICKS - 1)) begin
						s_nxt.pwr = sxch_pkg::PW_SLEEP; // see RL12
					end else begin
						s_nxt.wake_cnt = s_r.wake_cnt + 32'h0000_0001;
					end
				end
			end
			sxch_pkg::PW_HELD: begin
				if (!serial_connected) begin
					s_nxt.pwr = sxch_pkg::PW_SLEEP; // see RL13
				end
			end
			default: begin
				s_nxt.pwr = sxch_pkg::PW_SLEEP;
			end
		endcase

		// ------------------------------------------------------------
		// echo path
		// ------------------------------------------------------------
		s_nxt.level = s_r.peak_last ? last_peak_dist : max_peak_dist; // see RL3 RL4
		// beyond the stored range the reference does not apply
		s_nxt.accept = ~s_r.bkg_valid | (echo_dist > s_r.bkg_dist) |
			(echo_amp > echo_ref_amp); // see RL8
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{
				ack: 1'b0,
				rdata: 32'h0000_0000,
				last_op: 4'h0,
				param: 32'h0000_0000,
				addr: sxch_pkg::ADDR_DEFAULT,
				busy: 1'b0,
				resp_valid: 1'b0,
				resp: 32'h0000_0000,
				iir: sxch_pkg::IIR_DEFAULT,
				peak_last: sxch_pkg::PEAK_DEFAULT,
				wave: sxch_pkg::WAVE_DEFAULT,
				supp: sxch_pkg::SUPP_DEFAULT,
				fcal: sxch_pkg::FCAL_DEFAULT,
				bkg_valid: 1'b0,
				bkg_dist: 32'h0000_0000,
				bkg_cap: 1'b0,
				cal_clr: 1'b0,
				cal_go: 1'b0,
				meas_go: 1'b0,
				pwr: sxch_pkg::PW_SLEEP,
				wake_cnt: 32'h0000_0000,
				level: 32'h0000_0000,
				accept: 1'b1
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// outside SDI-12 mode the device never sleeps
	assign asleep = sdi12_mode & (s_r.pwr == sxch_pkg::PW_SLEEP); // see RL10
	assign serial_enable = ~asleep; // see RL11
	assign avs_readdata = s_r.rdata;
	assign level_dist = s_r.level;
	assign echo_accept = s_r.accept;
	assign bkg_capture = s_r.bkg_cap;
	assign bkg_range = s_r.bkg_dist;
	assign cal_clear = s_r.cal_clr;
	assign cal_start = s_r.cal_go;
	assign cal_forced = s_r.fcal;
	assign meas_start = s_r.meas_go;
	// code bit 0 drops the wave sentence, bit 1 the angle one
	assign wave_sentence_en = ~s_r.supp[0]; // see RL6
	assign angle_sentence_en = ~s_r.supp[1]; // see RL6
	assign iir_constant = s_r.iir;
	assign wave_window = s_r.wave;
endmodule // sxch_handler

// file: test/sxch_props.sv
// sxch_props: port checker of the extended command handler
`timescale 1ns/1ps
module sxch_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// echo path
	input wire logic [31:0] max_peak_dist,
	input wire logic [31:0] last_peak_dist,
	input wire logic [31:0] level_dist,
	input wire logic [15:0] echo_amp,
	input wire logic [15:0] echo_ref_amp,
	input wire logic echo_accept,
	input wire logic bkg_capture,
	input wire logic [31:0] bkg_range,
	// calibration, power
	input wire logic cal_start,
	input wire logic cal_clear,
	input wire logic [11:0] wave_window,
	input wire logic sdi12_mode,
	input wire logic serial_connected,
	input wire logic meas_done,
	input wire logic meas_start,
	input wire logic serial_enable,
	input wire logic asleep
);
	// ------------------------------------------------------------
	// one clock domain, so shared clocking and disable
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// at most one wait cycle per request
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held past one cycle");
	// level follows one of the two peak inputs, one cycle late
	chk_level_pick: assert property ($past(reset_n) |->
		level_dist == $past(max_peak_dist) || level_dist == $past(last_peak_dist))
		else $error("level distance not from a peak input");
	chk_port_closed: assert property (serial_enable == !asleep)
		else $error("serial ports open while asleep");
	chk_mode_awake: assert property (!sdi12_mode |-> !asleep)
		else $error("asleep outside sdi12 mode");
	chk_cal_pair: assert property (cal_start |-> cal_clear ##1 !cal_start)
		else $error("calibration strobes not paired");
	chk_bkg_pulse: assert property (bkg_capture |-> bkg_range != 32'h0 ##1 !bkg_capture)
		else $error("background capture without range");
	chk_bkg_none: assert property (bkg_range == 32'h0 |=> echo_accept)
		else $error("echo refused with no background");
	chk_echo_strong: assert property (echo_amp > echo_ref_amp |=> echo_accept)
		else $error("strong echo refused");
	chk_wave_max: assert property (wave_window <= 12'hE10)
		else $error("wave window above limit");
	chk_meas_pulse: assert property (meas_start |=> !meas_start)
		else $error("measure strobe longer than one cycle");
	// a connected host keeps an awake device awake unless meas_done ends a measurement
	chk_held_awake: assert property (sdi12_mode && !asleep && serial_connected && !meas_done
		|=> !asleep)
		else $error("device slept under serial connection");
endmodule // sxch_props

bind sxch_handler sxch_props i_props (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
	.max_peak_dist, .last_peak_dist, .level_dist, .echo_amp, .echo_ref_amp, .echo_accept,
	.bkg_capture, .bkg_range, .cal_start, .cal_clear, .wave_window, .sdi12_mode,
	.serial_connected, .meas_done, .meas_start, .serial_enable, .asleep);

// file: test/sxch_engine_model.sv
// sxch_engine_model: calibration and measurement engine beside the handler
`timescale 1ns/1ps
module sxch_engine_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// strobes and chosen latency
	input wire logic cal_start,
	input wire logic meas_start,
	input wire logic [7:0] lat,
	// completion
	output logic cal_done,
	output logic meas_done
);
	int cn;
	int mn;
	// a strobe arms a countdown, done pulses as it runs out
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cn <= 0;
			mn <= 0;
			cal_done <= 1'b0;
			meas_done <= 1'b0;
		end else begin
			cal_done <= (cn == 1);
			meas_done <= (mn == 1);
			cn <= cal_start ? lat : (cn > 0 ? cn - 1 : 0);
			mn <= meas_start ? lat : (mn > 0 ? mn - 1 : 0);
		end
	end
endmodule // sxch_engine_model

// file: test/tb.sv
// tb: self-checking bench of the extended command handler
`timescale 1ns/1ps
module tb;
	localparam int TC = 4;
	localparam int WT = 10;
	logic clk, reset_n, rd, wr, wq, acc, bcap, cdone, cclr, cst, cf, wen, aen;
	logic sdi, con, mdone, mst, sen, slp;
	logic [7:0] adr, lat;
	logic [11:0] wwin;
	logic [15:0] ea, er;
	logic [31:0] wd, rdat, mx, ls, ed, lvl, brg, iir;
	int fails = 0;
	int n_compared = 0;
	int ncap = 0;
	int ncal = 0;
	int nms = 0;

	sxch_handler #(.TICK_CYC(TC), .WAKE_TICKS(WT)) i_dut (.clk, .reset_n,
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wq), .max_peak_dist(mx), .last_peak_dist(ls),
		.echo_dist(ed), .echo_amp(ea), .echo_ref_amp(er), .level_dist(lvl),
		.echo_accept(acc), .bkg_capture(bcap), .bkg_range(brg), .cal_done(cdone),
		.cal_clear(cclr), .cal_start(cst), .cal_forced(cf), .wave_sentence_en(wen),
		.angle_sentence_en(aen), .iir_constant(iir), .wave_window(wwin), .sdi12_mode(sdi),
		.serial_connected(con), .meas_done(mdone), .meas_start(mst), .serial_enable(sen),
		.asleep(slp));
	sxch_engine_model i_eng (.clk, .reset_n, .cal_start(cst), .meas_start(mst), .lat,
		.cal_done(cdone), .meas_done(mdone));

	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		fails++;
		end_of_test();
	end
	// strobe counters
	always @(posedge clk) begin
		if (bcap === 1'b1) ncap <= ncap + 1;
		if (cst === 1'b1 && cclr === 1'b1) ncal <= ncal + 1;
		if (mst === 1'b1) nms <= nms + 1;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		@(posedge clk);
		while (wq !== 1'b0) @(posedge clk);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic cmd(input logic [4:0] c, input logic [31:0] p, output logic [31:0] r);
		logic [31:0] q;
		bus(1'b1, 8'h04, p, q);
		bus(1'b1, 8'h00, {27'h0, c}, q);
		bus(1'b0, 8'h10, 32'h0, r);
	endtask
	task automatic end_of_test();
		$display("fails %0d n_compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		bus(1'b0, 8'h14, 32'h0, q);
		chk("iir", 32'h0000_8000, q);
		bus(1'b0, 8'h20, 32'h0, q);
		chk("unmapped", 32'h0, q);
		chk("asleep", 32'h1, 32'(slp));
		chk("serial", 32'h0, 32'(sen));
	endtask
	// set then get, with the wave clamp and a non-binary flag
	task automatic t_echo();
		logic [31:0] q;
		logic [4:0] c [9] = '{5'h10, 5'h00, 5'h12, 5'h12, 5'h12, 5'h02, 5'h18, 5'h18, 5'h18};
		logic [31:0] p [9] = '{32'h1_0000, 32'h0, 32'hE10, 32'hFA0, 32'h0, 32'h0, 32'h1,
			32'h5, 32'h0};
		logic [31:0] e [9] = '{32'h1_0000, 32'h1_0000, 32'hE10, 32'hE10, 32'h0, 32'h0,
			32'h1, 32'h1, 32'h0};
		for (int i = 0; i < 9; i++) begin
			cmd(c[i], p[i], q);
			chk("echo", e[i], q);
		end
		chk("iir port", 32'h1_0000, iir);
		chk("fcal port", 32'h0, 32'(cf));
	endtask
	task automatic t_peak_supp();
		logic [31:0] q;
		for (int k = 0; k < 2; k++) begin
			cmd(5'h11, 32'(k), q);
			repeat (3) @(posedge clk);
			chk("level", k ? ls : mx, lvl);
		end
		for (int k = 0; k < 4; k++) begin
			cmd(5'h13, 32'(k), q);
			chk("wave en", 32'(!k[0]), 32'(wen));
			chk("angle en", 32'(!k[1]), 32'(aen));
		end
	endtask
	task automatic t_bkg();
		logic [31:0] q;
		cmd(5'h14, 32'h100, q);
		chk("bkg echo", 32'h100, q);
		chk("captures", 32'h1, 32'(ncap));
		chk("range", 32'h100, brg);
		repeat (2) @(posedge clk);
		chk("weak", 32'h0, 32'(acc));
		ea <= 16'h30;
		repeat (2) @(posedge clk);
		chk("strong", 32'h1, 32'(acc));
		ea <= 16'h10;
		cmd(5'h14, 32'h0, q);
		repeat (2) @(posedge clk);
		chk("cleared", 32'h1, 32'(acc && brg == 32'h0 && ncap == 1));
	endtask
	task automatic t_recal_std();
		logic [31:0] q;
		int n = 0;
		lat <= 8'h1E;
		bus(1'b1, 8'h00, 32'h6, q);
		do begin
			bus(1'b0, 8'h0C, 32'h0, q);
			n++;
		end while (q[0] === 1'b1 && n < 50);
		bus(1'b0, 8'h10, 32'h0, q);
		chk("recal", 32'h1, q);
		chk("recal busy", 32'h1, 32'(n > 1 && ncal == 1));
		cmd(5'h0A, 32'h0, q);
		chk("std", 32'h0, q);
	endtask
	task automatic t_power();
		logic [31:0] q;
		int n = 0;
		lat <= 8'h14;
		bus(1'b1, 8'h00, 32'h9, q);
		repeat (2) @(posedge clk);
		chk("measuring", 32'h1, 32'(sen));
		chk("meas strobe", 32'h1, 32'(nms));
		repeat (40) @(posedge clk);
		chk("slept", 32'h1, 32'(slp));
		bus(1'b1, 8'h00, 32'h5, q);
		// the wake state lands on the edge the bus task returns on
		@(posedge clk);
		while (slp === 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("window", 32'h1, 32'(n >= WT * TC - TC && n <= WT * TC + TC + 4));
		bus(1'b1, 8'h00, 32'h5, q);
		con <= 1'b1;
		repeat (3 * WT * TC) @(posedge clk);
		chk("held", 32'h0, 32'(slp));
		con <= 1'b0;
		repeat (5) @(posedge clk);
		chk("released", 32'h1, 32'(slp));
		// outside sdi-12 mode the sleeping state must not close the ports
		sdi <= 1'b0;
		repeat (2) @(posedge clk);
		chk("mode awake", 32'h0, 32'(slp));
		chk("mode serial", 32'h1, 32'(sen));
		sdi <= 1'b1;
	endtask
	task automatic t_defaults();
		logic [31:0] q;
		cmd(5'h12, 32'h100, q);
		cmd(5'h07, 32'h0, q);
		chk("defaults", 32'h1, q);
		bus(1'b0, 8'h18, 32'h0, q);
		chk("cfg", 32'h04B0_0000, q);
		chk("iir back", 32'h0000_8000, iir);
		chk("wave port", 32'h0000_04B0, 32'(wwin));
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, 8'h14, 32'h0, q);
		chk("after cycle", 32'h0000_8000, q);
	endtask

	// main sequence
	initial begin
		reset_n = 1'b0;
		{rd, wr, con} = 3'h0;
		sdi = 1'b1;
		adr = 8'h00;
		lat = 8'h04;
		wd = 32'h0;
		mx = 32'h111;
		ls = 32'h999;
		ed = 32'h50;
		ea = 16'h10;
		er = 16'h20;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_echo();
		t_peak_supp();
		t_bkg();
		t_recal_std();
		t_power();
		t_defaults();
		end_of_test();
	end
endmodule // tb
